// ===== src/cnt_dma.sv
// Counter mode and transfer logic: extended counting modes and a request
// interface that streams save data out or refills load registers.
// Assumes a classic Wishbone master and an outside transfer controller.
//
// Our own choice: the Wishbone register port.

`timescale 1ns/1ns

module cnt_dma (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire cnt_dma_pkg::enc_t enc_i,
    input wire logic timebase_sel_i,
    input wire logic gate_i,
    input wire logic bank_switch_i,
    input wire logic xfer_ack_i,
    output logic xfer_req_o,
    output logic irq_o,
    output logic [31:0] count_o
);

    cnt_dma_pkg::state_t s_q;
    cnt_dma_pkg::state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Merge a write word into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = val[8*i +: 8];
            end
        end
        return r;
    endfunction

    // True when the access touches the half chosen by the half-select bit.
    function automatic logic hits_half(input logic [3:0] be, input logic hi);
        return hi ? (be[3] | be[2]) : (be[1] | be[0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decoded fields and events.

    logic req_now;
    logic acc_read;
    logic acc_write;
    logic [2:0] mode;
    logic [1:0] phase;
    logic index_en;
    logic stream_en;
    logic dir_write;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic src_edge;
    logic count_tick;
    logic up;
    logic step;
    logic reload;
    logic phase_hit;
    logic gate_edge;

    // Field decode; encoder edges on the synchronised copies, the gate edge on the raw gate input.
    always_comb begin
        req_now = cyc_i & stb_i & ~s_q.ack;
        acc_read = req_now & ~we_i;
        // Writes land at the edge where the master samples ack high, so the
        // register and the master's view of the cycle change together.
        acc_write = cyc_i & stb_i & we_i & s_q.ack;
        mode = s_q.mode_cfg[cnt_dma_pkg::BIT_MODE_LO +: 3];
        phase = s_q.mode_cfg[cnt_dma_pkg::BIT_PHASE_LO +: 2];
        index_en = s_q.mode_cfg[cnt_dma_pkg::BIT_INDEX_EN];
        stream_en = s_q.xfer_cfg[cnt_dma_pkg::BIT_STREAM_EN];
        dir_write = s_q.xfer_cfg[cnt_dma_pkg::BIT_DIRECTION];
        a_rise = s_q.enc_s.a & ~s_q.enc_p.a;
        a_fall = ~s_q.enc_s.a & s_q.enc_p.a;
        b_rise = s_q.enc_s.b & ~s_q.enc_p.b;
        b_fall = ~s_q.enc_s.b & s_q.enc_p.b;
        gate_edge = gate_i & ~s_q.gate_p;
        // Phase encoding: bit 1 is A, bit 0 is B.
        phase_hit = ({s_q.enc_s.a, s_q.enc_s.b} == phase);
        // Source edge seen by normal counting; the prescaler passes one in eight.
        src_edge = a_rise;
        if (s_q.mode_cfg[cnt_dma_pkg::BIT_DIV8]) begin
            src_edge = a_rise & (s_q.div_cnt == cnt_dma_pkg::PRESCALE_LAST);
        end
    end

    // Counting step and direction per mode.
    always_comb begin
        step = 1'b0;
        up = 1'b1;
        reload = 1'b0;
        case (mode)
            cnt_dma_pkg::MODE_NORMAL: begin
                step = src_edge;
            end
            cnt_dma_pkg::MODE_QUAD_X1: begin
                // One count per full cycle: A rising with B low counts up.
                step = (a_rise & ~s_q.enc_s.b) | (a_fall & ~s_q.enc_s.b);
                up = a_rise;
                reload = index_en & phase_hit & s_q.enc_s.z;
            end
            cnt_dma_pkg::MODE_QUAD_X2: begin
                step = a_rise | a_fall;
                up = a_rise ^ s_q.enc_s.b;
                reload = index_en & phase_hit & s_q.enc_s.z;
            end
            cnt_dma_pkg::MODE_QUAD_X4: begin
                step = a_rise | a_fall | b_rise | b_fall;
                up = (a_rise | a_fall) ? (s_q.enc_s.a ^ s_q.enc_s.b)
                                       : ~(s_q.enc_s.a ^ s_q.enc_s.b);
                reload = index_en & phase_hit & s_q.enc_s.z;
            end
            cnt_dma_pkg::MODE_TWO_PULSE: begin
                step = a_rise ^ b_rise;
                up = a_rise;
                reload = index_en & s_q.enc_s.z;
            end
            cnt_dma_pkg::MODE_SYNC_SRC: begin
                // The fast clock runs freely; the source only enables counts.
                // With index set the edge detector is bypassed: level enables.
                step = index_en ? s_q.enc_s.a : a_rise;
            end
            default: begin
                step = 1'b0;
            end
        endcase
    end

    assign count_tick = step;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        logic last_write;
        logic inactive;
        logic hi;
        logic err_set;
        last_write = 1'b0;
        // Set when an error event occurs this cycle; it outranks a clear.
        err_set = 1'b0;
        s_d = s_q;
        inactive = s_q.bank_cfg[cnt_dma_pkg::BIT_INACTIVE_WR];
        hi = s_q.bank_cfg[cnt_dma_pkg::BIT_HALF_SEL];

        // Input sampling: the timebase select is only registered into fall_tick,
        // which qualifies no sampling; rising-source sync adds one more stage.
        s_d.fall_tick = timebase_sel_i;
        // The previous copy always trails the synchronised one, so edges are
        // seen in the right sense whichever path feeds the synchronised copy.
        s_d.enc_x = enc_i;
        s_d.enc_p = s_q.enc_s;
        if (s_q.mode_cfg[cnt_dma_pkg::BIT_SYNC_RISE]) begin
            s_d.enc_s = s_q.enc_x;
        end else begin
            s_d.enc_s = enc_i;
        end
        s_d.gate_p = gate_i;

        // Prescaler advances on each rising source edge.
        if (a_rise) begin
            s_d.div_cnt = s_q.div_cnt + 3'h1;
        end

        // Counter update; the index reload wins over a count.
        if (reload) begin
            s_d.count = s_q.load_a;
        end else if (count_tick) begin
            s_d.count = up ? s_q.count + 32'h1 : s_q.count - 32'h1;
        end

        // Read streaming: gate edges store into the two-deep FIFO.
        if (stream_en && !dir_write && gate_edge) begin
            if (s_q.fifo_cnt == 2'h2) begin
                s_d.overflow_armed = 1'b1;
            end else begin
                if (s_q.fifo_wr_sel) begin
                    s_d.save_sw = s_q.count;
                end else begin
                    s_d.save_hw = s_q.count;
                end
                s_d.fifo_wr_sel = ~s_q.fifo_wr_sel;
                s_d.fifo_cnt = s_q.fifo_cnt + 2'h1;
            end
        end

        // Register bus.
        s_d.ack = req_now;
        if (acc_write) begin
            case (adr_i)
                cnt_dma_pkg::ADDR_COUNT_MODE: begin
                    s_d.mode_cfg = 16'(merge({16'h0, s_q.mode_cfg}, dat_i, sel_i));
                end
                cnt_dma_pkg::ADDR_TRANSFER: begin
                    s_d.xfer_cfg = 16'(merge({16'h0, s_q.xfer_cfg}, dat_i, sel_i));
                end
                cnt_dma_pkg::ADDR_BANK_CTRL: begin
                    s_d.bank_cfg = 16'(merge({16'h0, s_q.bank_cfg}, dat_i, sel_i));
                end
                cnt_dma_pkg::ADDR_LOAD_A: begin
                    if (stream_en && dir_write && inactive && s_q.pending && !s_q.first_wr_done) begin
                        s_d.load_b = merge(s_q.load_b, dat_i, sel_i);
                        s_d.first_wr_done = 1'b1;
                    end else begin
                        s_d.load_a = merge(s_q.load_a, dat_i, sel_i);
                        last_write = inactive & s_q.first_wr_done;
                    end
                end
                cnt_dma_pkg::ADDR_LOAD_B: begin
                    s_d.load_b = merge(s_q.load_b, dat_i, sel_i);
                    if (inactive) begin
                        s_d.first_wr_done = 1'b1;
                    end else begin
                        last_write = hits_half(sel_i, hi);
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads by address; an acknowledge reads the FIFO head instead.
        s_d.rdata = cnt_dma_pkg::WORD_RESET;
        if (acc_read) begin
            case (adr_i)
                cnt_dma_pkg::ADDR_COUNT_MODE: s_d.rdata = {16'h0, s_q.mode_cfg};
                cnt_dma_pkg::ADDR_TRANSFER: begin
                    s_d.rdata[cnt_dma_pkg::BIT_PENDING] = s_q.pending;
                    s_d.rdata[cnt_dma_pkg::BIT_ERROR] = s_q.error;
                    s_d.rdata[cnt_dma_pkg::BIT_HEAD] = s_q.head;
                end
                cnt_dma_pkg::ADDR_SAVE_HW: s_d.rdata = s_q.save_hw;
                cnt_dma_pkg::ADDR_SAVE_SW: s_d.rdata = s_q.save_sw;
                cnt_dma_pkg::ADDR_LOAD_A: s_d.rdata = s_q.load_a;
                cnt_dma_pkg::ADDR_LOAD_B: s_d.rdata = s_q.load_b;
                cnt_dma_pkg::ADDR_COUNT: s_d.rdata = s_q.count;
                cnt_dma_pkg::ADDR_BANK_CTRL: s_d.rdata = {16'h0, s_q.bank_cfg};
                default: s_d.rdata = cnt_dma_pkg::WORD_RESET;
            endcase
            if (xfer_ack_i && stream_en && !dir_write) begin
                s_d.rdata = s_q.head ? s_q.save_sw : s_q.save_hw;
            end
            // A read of the head register pops it, by acknowledge or by address.
            if ((xfer_ack_i || adr_i == (s_q.head ? cnt_dma_pkg::ADDR_SAVE_SW
                                                  : cnt_dma_pkg::ADDR_SAVE_HW))
                && stream_en && !dir_write && s_q.fifo_cnt != 2'h0) begin
                s_d.head = ~s_q.head;
                s_d.fifo_cnt = s_d.fifo_cnt - 2'h1;
                if (s_q.overflow_armed) begin
                    s_d.error = 1'b1;
                    err_set = 1'b1;
                    s_d.overflow_armed = 1'b0;
                end
            end
        end

        // Request: read side follows FIFO contents, write side the bank switch.
        if (stream_en && !dir_write) begin
            s_d.pending = (s_d.fifo_cnt != 2'h0);
        end else if (stream_en && dir_write) begin
            if (last_write) begin
                s_d.pending = 1'b0;
                s_d.first_wr_done = 1'b0;
            end
            if (bank_switch_i) begin
                if (s_q.pending) begin
                    s_d.error = 1'b1;
                    err_set = 1'b1;
                end
                s_d.pending = 1'b1;
                s_d.first_wr_done = 1'b0;
            end
        end else begin
            s_d.pending = 1'b0;
        end

        // Writing the config register clears the error and restarts the FIFO.
        if (acc_write && adr_i == cnt_dma_pkg::ADDR_TRANSFER) begin
            s_d.error = err_set;
            s_d.fifo_cnt = 2'h0;
            s_d.head = 1'b0;
            s_d.fifo_wr_sel = 1'b0;
            s_d.pending = 1'b0;
            s_d.overflow_armed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; the request is a registered level.
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign xfer_req_o = s_q.pending;
    assign irq_o = s_q.pending & s_q.xfer_cfg[cnt_dma_pkg::BIT_RAISE_IRQ];
    assign count_o = s_q.count;

endmodule

// ===== src/cnt_dma_pkg.sv
// Package for the counter mode and transfer logic: offsets, fields, types.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package cnt_dma_pkg;

    // Register byte addresses.
    localparam logic [11:0] ADDR_COUNT_MODE = 12'h0B0;
    localparam logic [11:0] ADDR_TRANSFER = 12'h0B8;
    localparam logic [11:0] ADDR_SAVE_HW = 12'h0C0;
    localparam logic [11:0] ADDR_SAVE_SW = 12'h0C4;
    localparam logic [11:0] ADDR_LOAD_A = 12'h0C8;
    localparam logic [11:0] ADDR_LOAD_B = 12'h0CC;
    localparam logic [11:0] ADDR_COUNT = 12'h0D0;
    localparam logic [11:0] ADDR_BANK_CTRL = 12'h0D4;

    // Counting mode register fields.
    localparam int BIT_SYNC_RISE = 13;
    localparam int BIT_DIV8 = 12;
    localparam int BIT_PHASE_LO = 5;
    localparam int BIT_INDEX_EN = 4;
    localparam int BIT_MODE_LO = 0;

    // Transfer config fields.
    localparam int BIT_RAISE_IRQ = 2;
    localparam int BIT_DIRECTION = 1;
    localparam int BIT_STREAM_EN = 0;

    // Transfer status fields.
    localparam int BIT_PENDING = 15;
    localparam int BIT_ERROR = 14;
    localparam int BIT_HEAD = 13;

    // Bank control fields.
    localparam int BIT_INACTIVE_WR = 7;
    localparam int BIT_HALF_SEL = 9;

    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_QUAD_X1 = 3'b001,
        MODE_QUAD_X2 = 3'b010,
        MODE_QUAD_X4 = 3'b011,
        MODE_TWO_PULSE = 3'b100,
        MODE_SYNC_SRC = 3'b110
    } count_mode_t;

    // Encoder inputs travel together.
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } enc_t;

    // Whole state of the block.
    typedef struct packed {
        logic [15:0] mode_cfg;
        logic [15:0] xfer_cfg;
        logic [15:0] bank_cfg;
        logic [31:0] count;
        logic [31:0] save_hw;
        logic [31:0] save_sw;
        logic [31:0] load_a;
        logic [31:0] load_b;
        // Extra stage used only by the rising-source option.
        enc_t enc_x;
        enc_t enc_s;
        enc_t enc_p;
        logic gate_p;
        logic [2:0] div_cnt;
        logic fall_tick;
        logic [1:0] fifo_cnt;
        logic fifo_wr_sel;
        logic head;
        logic pending;
        logic error;
        logic overflow_armed;
        logic first_wr_done;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage

// ===== test/cnt_dma_props.sv
// Checker for the counter mode and transfer block, attached to its ports.
// Assumes a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ns
module cnt_dma_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire cnt_dma_pkg::enc_t enc_i,
    input wire logic gate_i,
    input wire logic bank_switch_i,
    input wire logic xfer_req_o,
    input wire logic irq_o,
    input wire logic [31:0] count_o
);
    logic [15:0] cfg_q;
    logic [15:0] mode_q;
    logic wr;
    ////////////////////////////////////////
    // Shadow copies of the transfer config and counting mode registers, taken at the ack edge.
    assign wr = cyc_i && stb_i && we_i && ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 16'h0000;
            mode_q <= 16'h0000;
        end else begin
            if (wr && adr_i == cnt_dma_pkg::ADDR_TRANSFER) cfg_q <= dat_i[15:0];
            if (wr && adr_i == cnt_dma_pkg::ADDR_COUNT_MODE) mode_q <= dat_i[15:0];
        end
    end
    ////////////////////////////////////////
    // Synchronisers delay encoder edges, so quiet means six still cycles.
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence enc_quiet_s;
        $stable(enc_i) [*6];
    endsequence
    ack_latency_a: assert property (take_s |=> ack_o) else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    irq_follow_a: assert property (irq_o == (xfer_req_o && cfg_q[2]))
        else $error("irq mismatch");
    switch_raise_a: assert property (bank_switch_i && cfg_q[0] && cfg_q[1]
        |=> xfer_req_o) else $error("no request on switch");
    gate_raise_a: assert property ($rose(gate_i) && cfg_q[0] && !cfg_q[1]
        |-> ##[1:2] xfer_req_o) else $error("no request on save");
    pending_bit_a: assert property (ack_o && !we_i && adr_i == cnt_dma_pkg::ADDR_TRANSFER
        |-> dat_o[15] == $past(xfer_req_o)) else $error("pending bit wrong");
    still_count_a: assert property (!mode_q[4]
        && mode_q[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4}
        ##0 enc_quiet_s |-> $stable(count_o)) else $error("count moved");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !xfer_req_o && !ack_o) else $error("busy after reset");
endmodule
bind cnt_dma cnt_dma_props chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .enc_i(enc_i), .gate_i(gate_i), .bank_switch_i(bank_switch_i),
    .xfer_req_o(xfer_req_o), .irq_o(irq_o), .count_o(count_o));

// ===== test/quad_enc_model.sv
// Encoder stand-in: drives A, B and Z lines into the counter.
// Assumes the bench asks for a step or a raw state just after a rising edge.
`timescale 1ns/1ns
module quad_enc_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic fwd_i,
    input wire logic load_i,
    input wire logic [1:0] ab_i,
    input wire logic z_i,
    output cnt_dma_pkg::enc_t enc_o
);
    logic [1:0] ab_q;
    // Gray stepping moves one line at a time, as a real shaft does.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ab_q <= 2'h0;
        end else if (load_i) begin
            ab_q <= ab_i;
        end else if (step_i) begin
            ab_q <= fwd_i ? {~ab_q[0], ab_q[1]} : {ab_q[0], ~ab_q[1]};
        end
    end
    assign enc_o = {ab_q, z_i};
endmodule

// ===== test/cnt_dma_tb.sv
// Self-checking bench for the counter mode and transfer block.
// Assumes the design answers a Wishbone take with ack one cycle later.
`timescale 1ns/1ns
module cnt_dma_tb;
    logic clk, rst, cyc, stb, we, tbs, gate, bsw, xack, req, irq, ack;
    logic stp, fwd, ld, z;
    logic [1:0] ab;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, cnt, r, c0, d, v;
    cnt_dma_pkg::enc_t enc;
    int bad_count, tests_run, cycles, m, p;
    integer seed = 86971;
    cnt_dma uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack), .enc_i(enc),
        .timebase_sel_i(tbs), .gate_i(gate), .bank_switch_i(bsw), .xfer_ack_i(xack),
        .xfer_req_o(req), .irq_o(irq), .count_o(cnt));
    quad_enc_model enc_m (.clk_i(clk), .rst_i(rst), .step_i(stp), .fwd_i(fwd),
        .load_i(ld), .ab_i(ab), .z_i(z), .enc_o(enc));
    ////////////////////////////////////////
    // Expected values.
    function automatic logic [31:0] per_cycle(input int md);
        return 32'h1 << (md - 1);
    endfunction
    function automatic logic [31:0] mode_word(input int md, input int ix, input int ph);
        return 32'((1 << cnt_dma_pkg::BIT_SYNC_RISE) | (ph << cnt_dma_pkg::BIT_PHASE_LO)
            | (ix << cnt_dma_pkg::BIT_INDEX_EN) | md);
    endfunction
    ////////////////////////////////////////
    // Bus cycle, comparison and stimulus helpers.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dd,
        input logic [3:0] s, input logic k);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= dd;
        sel <= s;
        xack <= k;
        do @(posedge clk); while (ack !== 1'b1);
        r = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        xack <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic step(input logic f);
        stp <= 1'b1;
        fwd <= f;
        @(posedge clk);
        stp <= 1'b0;
        wt(4 + ($random(seed) & 3));
    endtask
    task automatic setab(input logic [1:0] s);
        ld <= 1'b1;
        ab <= s;
        @(posedge clk);
        ld <= 1'b0;
        wt(6);
    endtask
    task automatic pulse(input int which);
        if (which == 0) gate <= 1'b1;
        else bsw <= 1'b1;
        @(posedge clk);
        gate <= 1'b0;
        bsw <= 1'b0;
        wt(3);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Clock and hang guard; the whole run needs well under a thousand cycles.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    ////////////////////////////////////////
    // Main sequence.
    initial begin
        {rst, cyc, stb, we, tbs, gate, bsw, xack, stp, fwd, ld, z} = 12'h800;
        {adr, sel, dw, ab} = '0;
        wt(4);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, cnt_dma_pkg::ADDR_TRANSFER, 0, 4'hF, 0);
        chk("status after reset", 32'h0, r & 32'hE000);
        bus(0, 12'h0FC, 0, 4'hF, 0);
        chk("unmapped read", 32'h0, r);
        for (m = 1; m <= 3; m++) begin
            bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(m, 0, 0), 4'hF, 0);
            c0 = cnt;
            repeat (4) step(1);
            d = cnt - c0;
            chk("counts per cycle", per_cycle(m), d[31] ? -d : d);
            repeat (4) step(0);
            chk("count after reverse", c0, cnt);
        end
        bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(6, 0, 0), 4'hF, 0);
        c0 = cnt;
        repeat (4) step(1);
        chk("sync source count", c0 + 32'h1, cnt);
        v = mode_word(0, 0, 0) | (32'h1 << cnt_dma_pkg::BIT_DIV8);
        bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, v, 4'hF, 0);
        c0 = cnt;
        repeat (32) step(1);
        chk("prescaled count", c0 + 32'h1, cnt);
        bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(4, 0, 0), 4'hF, 0);
        c0 = cnt;
        repeat (3) begin
            setab(2'h2);
            setab(2'h0);
        end
        setab(2'h1);
        setab(2'h0);
        chk("two pulse net", c0 + 32'h2, cnt);
        v = $random(seed);
        bus(1, cnt_dma_pkg::ADDR_LOAD_A, v, 4'hF, 0);
        bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(4, 1, 0), 4'hF, 0);
        z <= 1'b1;
        wt(6);
        chk("two pulse reload", v, cnt);
        z <= 1'b0;
        for (p = 0; p < 4; p++) begin
            bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(3, 1, p), 4'hF, 0);
            setab(p[1:0]);
            v = $random(seed);
            bus(1, cnt_dma_pkg::ADDR_LOAD_A, v, 4'hF, 0);
            c0 = cnt;
            bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(3, 1, p ^ 3), 4'hF, 0);
            z <= 1'b1;
            wt(6);
            chk("wrong phase holds", c0, cnt);
            bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(3, 1, p), 4'hF, 0);
            wt(6);
            chk("index reload", v, cnt);
            z <= 1'b0;
        end
        bus(1, cnt_dma_pkg::ADDR_BANK_CTRL, 32'h200, 4'hF, 0);
        bus(1, cnt_dma_pkg::ADDR_TRANSFER, 32'h7, 4'hF, 0);
        pulse(1);
        chk("request on switch", 32'h1, {31'h0, req});
        chk("irq with request", 32'h1, {31'h0, irq});
        bus(1, cnt_dma_pkg::ADDR_LOAD_B, $random(seed), 4'h3, 0);
        chk("low half keeps request", 32'h1, {31'h0, req});
        bus(1, cnt_dma_pkg::ADDR_LOAD_B, $random(seed), 4'hC, 0);
        chk("high half clears", 32'h0, {31'h0, req});
        bus(1, cnt_dma_pkg::ADDR_BANK_CTRL, 32'h80, 4'hF, 0);
        pulse(1);
        bus(1, cnt_dma_pkg::ADDR_LOAD_B, $random(seed), 4'hF, 0);
        chk("first write keeps request", 32'h1, {31'h0, req});
        bus(1, cnt_dma_pkg::ADDR_LOAD_A, $random(seed), 4'hF, 0);
        chk("second write clears", 32'h0, {31'h0, req});
        pulse(1);
        pulse(1);
        bus(0, cnt_dma_pkg::ADDR_TRANSFER, 0, 4'hF, 0);
        chk("underflow status", 32'hC000, r & 32'hC000);
        bus(1, cnt_dma_pkg::ADDR_COUNT_MODE, mode_word(3, 0, 0), 4'hF, 0);
        bus(1, cnt_dma_pkg::ADDR_TRANSFER, 32'h1, 4'hF, 0);
        c0 = cnt;
        pulse(0);
        chk("request on save", 32'h1, {31'h0, req});
        bus(0, cnt_dma_pkg::ADDR_TRANSFER, 0, 4'hF, 0);
        chk("head on hardware", 32'h8000, r & 32'hE000);
        bus(0, cnt_dma_pkg::ADDR_SAVE_HW, 0, 4'hF, 1);
        chk("streamed save", c0, r);
        bus(0, cnt_dma_pkg::ADDR_TRANSFER, 0, 4'hF, 0);
        chk("head toggles", 32'h2000, r & 32'hE000);
        repeat (3) pulse(0);
        bus(0, cnt_dma_pkg::ADDR_SAVE_SW, 0, 4'hF, 1);
        bus(0, cnt_dma_pkg::ADDR_TRANSFER, 0, 4'hF, 0);
        chk("overflow flag", 32'h4000, r & 32'h4000);
        results();
    end
endmodule
